// >>> design/usp_pkg.sv
// Purpose: constants and carriers of the uart shadow data port
// Assumes: one 250 MHz clock, synchronous active-high reset
// Notes: every offset is a full byte address on the register bus
package usp_pkg;
   // shadow window: sixteen word locations sharing one storage
   localparam logic [31:0] SHADOW_RX_TX_DATA_2 = 32'h50001038;
   localparam logic [31:0] SHADOW_RX_TX_DATA_3 = 32'h5000103c;
   localparam logic [31:0] SHADOW_FIRST = SHADOW_RX_TX_DATA_2 - 32'h8;
   localparam logic [31:0] SHADOW_LAST = SHADOW_FIRST + 32'h3c;
   // control and status words
   localparam logic [31:0] FIFO_CONTROL = 32'h50001008;
   localparam logic [31:0] LINE_STATUS = 32'h50001014;
   localparam logic [31:0] BAUD_DIV = 32'h50001100;
   localparam logic [31:0] IRQ_STATUS = 32'h50001104;
   localparam logic [31:0] IRQ_MASK = 32'h50001108;
   // field positions
   localparam int FCR_FIFO_EN_BIT = 0;
   localparam int FCR_IR_MODE_BIT = 1;
   localparam int LSR_DR_BIT = 0;
   localparam int LSR_OE_BIT = 1;
   localparam int LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
   localparam int IRQ_OVERRUN = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_TX_LOST = 2;
   // sizes and reset values
   localparam logic [4:0] FIFO_DEPTH = 5'h10;
   localparam logic [15:0] BAUD_DIV_RESET = 16'h000f;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // bus requests from the master
   typedef struct packed {
      logic awvalid;
      logic [31:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [31:0] araddr;
      logic rready;
   } usp_axi_req_t;

   // bus answers to the master
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } usp_axi_rsp_t;

   // one received character with its strobe
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } usp_byte_t;

   // transmit framer, gray along idle-start-data-stop
   typedef enum logic [1:0] {
      TX_IDLE = 2'h0,
      TX_START = 2'h1,
      TX_DATA = 2'h3,
      TX_STOP = 2'h2
   } usp_tx_state_t;

   // whole state of the port
   typedef struct packed {
      usp_tx_state_t txSt;
      logic [2:0] bitIdx;
      logic [15:0] tick;
      logic [7:0] shift;
      logic serOut;
      logic irOutN;
      logic [15:0][7:0] rxMem;
      logic [3:0] rxRd;
      logic [3:0] rxWr;
      logic [4:0] rxCnt;
      logic [15:0][7:0] txMem;
      logic [3:0] txRd;
      logic [3:0] txWr;
      logic [4:0] txCnt;
      logic fifoEn;
      logic irMode;
      logic overrun;
      logic [15:0] baudDiv;
      logic [2:0] irqSt;
      logic [2:0] irqMask;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } usp_state_t;
endpackage : usp_pkg

// >>> design/usp_shadow_port.sv
// Purpose: shadow receive/transmit data port of a uart on AXI4-Lite
// Assumes: character inputs arrive already deserialised, one cycle each
// Notes: transmit side frames 8N1 at one bit per baud tick
`timescale 1ns/100ps
`default_nettype none
module usp_shadow_port (
   input wire logic ref_clk,
   input wire logic srst,
   input wire usp_pkg::usp_axi_req_t axiReq,
   output var usp_pkg::usp_axi_rsp_t axiRsp,
   input wire usp_pkg::usp_byte_t serRx,
   input wire usp_pkg::usp_byte_t irRx,
   output logic serOut,
   output logic irOutN,
   output logic irq
);
   import usp_pkg::*;

   usp_state_t s; // registered state
   usp_state_t next_s; // its next value
   logic wrFire; // write address and data taken together
   logic rdFire; // read address taken
   logic wrShadow; // write lands in the shadow window
   logic rdShadow; // read lands in the shadow window
   logic flush; // fifo mode changes, both fifos emptied
   logic rxPop; // head leaves the receive fifo
   logic txLoad; // framer takes the next character
   logic advance; // baud tick while framing
   logic lineBit; // level of the serial line next cycle
   usp_byte_t rxIn; // character from the selected input
   logic [7:0] rxHead; // character a shadow read returns
   logic [7:0] wrByte; // character a shadow write supplies
   logic dataReady; // at least one character unread

   // any aligned word inside the window, all alike
   function automatic logic inShadow(input logic [31:0] a);
      return a >= SHADOW_FIRST && a <= SHADOW_LAST && a[1:0] == 2'h0;
   endfunction : inShadow

   // handshakes answer from state; write readies also need both master valids
   always_comb begin
      axiRsp.awready = axiReq.awvalid && axiReq.wvalid && !s.bvalid;
      axiRsp.wready = axiReq.awvalid && axiReq.wvalid && !s.bvalid;
      axiRsp.bvalid = s.bvalid;
      axiRsp.bresp = s.bresp;
      axiRsp.arready = !s.rvalid;
      axiRsp.rvalid = s.rvalid;
      axiRsp.rdata = s.rdata;
      axiRsp.rresp = s.rresp;
   end

   // flop-driven line outputs, interrupt ORed from masked status flops
   assign serOut = s.serOut;
   assign irOutN = s.irOutN;
   assign irq = |(s.irqSt & s.irqMask);

   // plain views used by the next-state logic
   assign rxHead = s.rxMem[s.rxRd];
   assign wrByte = axiReq.wdata[7:0];
   assign dataReady = s.rxCnt != 5'h0;

   // whole next-state computation
   always_comb begin
      next_s = s;
      wrFire = axiReq.awvalid && axiReq.wvalid && !s.bvalid;
      rdFire = axiReq.arvalid && !s.rvalid;
      wrShadow = wrFire && inShadow(axiReq.awaddr) && axiReq.wstrb[0];
      rdShadow = rdFire && inShadow(axiReq.araddr);
      flush = wrFire && axiReq.awaddr == FIFO_CONTROL
         && axiReq.wstrb[0]
         && axiReq.wdata[FCR_FIFO_EN_BIT] != s.fifoEn;
      rxPop = rdShadow && dataReady;
      txLoad = s.txSt == TX_IDLE && s.txCnt != 5'h0;
      advance = s.txSt != TX_IDLE && s.tick == 16'h0;
      rxIn = s.irMode ? irRx : serRx;
      lineBit = 1'b1;

      // answers leave once the master takes them
      if (s.bvalid && axiReq.bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.rvalid && axiReq.rready) begin
         next_s.rvalid = 1'b0;
      end

      // register reads; clears come before hardware sets
      if (rdFire) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = 32'h0;
         if (inShadow(axiReq.araddr)) begin
            next_s.rdata[7:0] = dataReady ? rxHead : 8'h0;
         end else begin
            case (axiReq.araddr)
               FIFO_CONTROL: begin
                  next_s.rdata[FCR_FIFO_EN_BIT] = s.fifoEn;
                  next_s.rdata[FCR_IR_MODE_BIT] = s.irMode;
               end
               LINE_STATUS: begin
                  next_s.rdata[LSR_DR_BIT] = dataReady;
                  next_s.rdata[LSR_OE_BIT] = s.overrun;
                  next_s.rdata[LSR_TX_HOLDING_EMPTY_FLAG_BIT] = s.txCnt == 5'h0;
                  next_s.overrun = 1'b0;
               end
               BAUD_DIV: next_s.rdata[15:0] = s.baudDiv;
               IRQ_STATUS: next_s.rdata[2:0] = s.irqSt;
               IRQ_MASK: next_s.rdata[2:0] = s.irqMask;
               default: next_s.rresp = RESP_SLVERR;
            endcase
         end
      end

      // register writes
      if (wrFire) begin
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         if (!inShadow(axiReq.awaddr)) begin
            case (axiReq.awaddr)
               FIFO_CONTROL: begin
                  if (axiReq.wstrb[0]) begin
                     next_s.fifoEn = axiReq.wdata[FCR_FIFO_EN_BIT];
                     next_s.irMode = axiReq.wdata[FCR_IR_MODE_BIT];
                  end
               end
               BAUD_DIV: begin
                  if (axiReq.wstrb[0]) begin
                     next_s.baudDiv[7:0] = axiReq.wdata[7:0];
                  end
                  if (axiReq.wstrb[1]) begin
                     next_s.baudDiv[15:8] = axiReq.wdata[15:8];
                  end
               end
               IRQ_STATUS: begin
                  // write one to clear
                  if (axiReq.wstrb[0]) begin
                     next_s.irqSt = s.irqSt & ~axiReq.wdata[2:0];
                  end
               end
               IRQ_MASK: begin
                  if (axiReq.wstrb[0]) begin
                     next_s.irqMask = axiReq.wdata[2:0];
                  end
               end
               LINE_STATUS: ; // read only, write ignored
               default: next_s.bresp = RESP_SLVERR;
            endcase
         end
      end

      // receive side
      if (s.fifoEn) begin
         if (rxPop) begin
            next_s.rxRd = s.rxRd + 4'h1;
         end
         if (rxIn.valid && s.rxCnt == FIFO_DEPTH && !rxPop) begin
            next_s.overrun = 1'b1;
            next_s.irqSt[IRQ_OVERRUN] = 1'b1;
            next_s.rxCnt = s.rxCnt;
         end else if (rxIn.valid) begin
            next_s.rxMem[s.rxWr] = rxIn.data;
            next_s.rxWr = s.rxWr + 4'h1;
            next_s.irqSt[IRQ_RX] = 1'b1;
            next_s.rxCnt = rxPop ? s.rxCnt : s.rxCnt + 5'h1;
         end else if (rxPop) begin
            next_s.rxCnt = s.rxCnt - 5'h1;
         end
      end else begin
         if (rxIn.valid) begin
            next_s.rxMem[0] = rxIn.data;
            next_s.rxCnt = 5'h1;
            next_s.irqSt[IRQ_RX] = 1'b1;
            if (dataReady && !rxPop) begin
               next_s.overrun = 1'b1;
               next_s.irqSt[IRQ_OVERRUN] = 1'b1;
            end
         end else if (rxPop) begin
            next_s.rxCnt = 5'h0;
         end
      end

      // transmit side: store the written character
      if (s.fifoEn) begin
         if (txLoad) begin
            next_s.txRd = s.txRd + 4'h1;
         end
         if (wrShadow && s.txCnt == FIFO_DEPTH) begin
            next_s.irqSt[IRQ_TX_LOST] = 1'b1;
            next_s.txCnt = txLoad ? s.txCnt - 5'h1 : s.txCnt;
         end else if (wrShadow) begin
            next_s.txMem[s.txWr] = wrByte;
            next_s.txWr = s.txWr + 4'h1;
            next_s.txCnt = txLoad ? s.txCnt : s.txCnt + 5'h1;
         end else if (txLoad) begin
            next_s.txCnt = s.txCnt - 5'h1;
         end
      end else begin
         if (wrShadow) begin
            next_s.txMem[0] = wrByte;
            next_s.txCnt = 5'h1;
         end else if (txLoad) begin
            next_s.txCnt = 5'h0;
         end
      end

      // baud tick counts down while a frame runs
      if (s.txSt == TX_IDLE || advance) begin
         next_s.tick = s.baudDiv;
      end else begin
         next_s.tick = s.tick - 16'h1;
      end

      // 8N1 framer, lsb first
      case (s.txSt)
         TX_IDLE: begin
            if (txLoad) begin
               next_s.txSt = TX_START;
               next_s.shift = s.txMem[s.txRd];
            end
         end
         TX_START: begin
            if (advance) begin
               next_s.txSt = TX_DATA;
               next_s.bitIdx = 3'h0;
            end
         end
         TX_DATA: begin
            if (advance) begin
               next_s.shift = {1'b0, s.shift[7:1]};
               next_s.bitIdx = s.bitIdx + 3'h1;
               if (s.bitIdx == 3'h7) begin
                  next_s.txSt = TX_STOP;
               end
            end
         end
         TX_STOP: begin
            if (advance) begin
               next_s.txSt = TX_IDLE;
            end
         end
         default: next_s.txSt = TX_IDLE;
      endcase

      // line level to the selected output
      case (next_s.txSt)
         TX_START: lineBit = 1'b0;
         TX_DATA: lineBit = next_s.shift[0];
         default: lineBit = 1'b1;
      endcase
      next_s.serOut = next_s.irMode ? 1'b1 : lineBit;
      next_s.irOutN = next_s.irMode ? lineBit : 1'b1;

      // fifo mode change empties both fifos, frame in flight finishes
      if (flush) begin
         next_s.rxRd = 4'h0;
         next_s.rxWr = 4'h0;
         next_s.rxCnt = 5'h0;
         next_s.txRd = 4'h0;
         next_s.txWr = 4'h0;
         next_s.txCnt = 5'h0;
      end
   end

   // single state register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= '0;
         s.serOut <= 1'b1;
         s.irOutN <= 1'b1;
         s.baudDiv <= BAUD_DIV_RESET;
      end else begin
         s <= next_s;
      end
   end

   // checks on the port behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence headRead;
      rxPop;
   endsequence
   sequence txLoadWire;
      txLoad && !wrFire && !s.irMode;
   endsequence
   sequence startBitWire;
      !serOut && irOutN;
   endsequence

   rx_head_a: assert property (
      headRead |=> s.rvalid && s.rdata[7:0] == $past(rxHead))
      else $error("shadow read did not return fifo head");
   upper_zero_a: assert property (
      rdShadow |=> s.rdata[31:8] == 24'h0 && s.rresp == RESP_OKAY)
      else $error("shadow read upper bits not zero");
   ready_flag_a: assert property (
      rdFire && axiReq.araddr == LINE_STATUS
      |=> s.rdata[LSR_DR_BIT] == $past(dataReady))
      else $error("line status data ready wrong");
   rx_overwrite_a: assert property (
      !s.fifoEn && rxIn.valid && dataReady && !rxPop && !flush
      |=> s.overrun && s.rxCnt == 5'h1 && s.irqSt[IRQ_OVERRUN])
      else $error("overwrite did not flag overrun");
   rx_full_drop_a: assert property (
      s.fifoEn && rxIn.valid && s.rxCnt == FIFO_DEPTH && !rxPop && !flush
      |=> s.rxCnt == FIFO_DEPTH && s.overrun
          && s.rxWr == $past(s.rxWr))
      else $error("full receive fifo changed");
   hold_clear_a: assert property (
      !s.fifoEn && wrShadow && !flush |=> s.txCnt == 5'h1)
      else $error("holding empty not cleared by write");
   tx_overwrite_a: assert property (
      !s.fifoEn && wrShadow && !flush |=> s.txMem[0] == $past(wrByte))
      else $error("pending character not overwritten");
   tx_accept_a: assert property (
      s.fifoEn && wrShadow && s.txCnt < FIFO_DEPTH && !txLoad && !flush
      |=> s.txCnt == $past(s.txCnt) + 5'h1)
      else $error("transmit fifo refused a write with room");
   tx_lost_a: assert property (
      s.fifoEn && wrShadow && s.txCnt == FIFO_DEPTH && !flush
      |=> s.irqSt[IRQ_TX_LOST] && s.txWr == $past(s.txWr))
      else $error("write into full fifo not dropped");
   start_bit_a: assert property (
      txLoadWire |=> startBitWire)
      else $error("start bit missing on wired output");
endmodule : usp_shadow_port
`default_nettype wire

// >>> sim/tb.sv
// Purpose: self-checking bench of the uart shadow data port
// Assumes: bench is the bus master, partner model is the remote uart
// Notes: frames shortened by writing a small baud divisor
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failCount++; \
   $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module tb;
   import usp_pkg::*;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   usp_axi_req_t axiReq = '0; // master requests
   usp_axi_rsp_t axiRsp;
   usp_byte_t serRx;
   usp_byte_t irRx;
   logic serOut;
   logic irOutN;
   logic irq;
   logic sendGo = 1'b0; // partner character request
   logic sendIr = 1'b0;
   logic [7:0] sendData = 8'h00;
   logic irSel = 1'b0; // partner listens on infrared line
   logic [15:0] bitDiv = 16'h000f; // partner copy of the divisor
   logic [31:0] rd; // last read data
   logic [1:0] lastResp; // last response code
   int failCount = 0;
   int compares = 0;
   int i;
   always #2 ref_clk = ~ref_clk;
   usp_shadow_port usp_shadow_port_i (.ref_clk(ref_clk), .srst(srst),
      .axiReq(axiReq), .axiRsp(axiRsp), .serRx(serRx), .irRx(irRx),
      .serOut(serOut), .irOutN(irOutN), .irq(irq));
   usp_remote_uart usp_remote_uart_i (.ref_clk(ref_clk), .sendGo(sendGo),
      .sendIr(sendIr), .sendData(sendData), .irSel(irSel), .bitDiv(bitDiv),
      .serOut(serOut), .irOutN(irOutN), .serRx(serRx), .irRx(irRx));
   // verdict, reached from the end and from any wait that runs out
   task automatic summarize();
      $display("compares %0d fail_count %0d", compares, failCount);
      if (failCount == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   task automatic hang();
      failCount++;
      $display("mismatch at %0t: wait ran out, got %h exp %h", $time, 0, 1);
      summarize();
   endtask : hang
   // address and data offered together, held until taken
   task automatic axiWrite(input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= 4'hf;
      axiReq.bready <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end
      while (!(axiRsp.awready && axiRsp.wready) && n < 64);
      if (n >= 64) hang();
      axiReq.awvalid <= 1'b0;
      axiReq.wvalid <= 1'b0;
      n = 0;
      do begin @(posedge ref_clk); n++; end
      while (axiRsp.bvalid !== 1'b1 && n < 64);
      if (n >= 64) hang();
      lastResp = axiRsp.bresp;
      axiReq.bready <= 1'b0;
   endtask : axiWrite
   task automatic axiRead(input logic [31:0] a);
      int n;
      @(posedge ref_clk);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      n = 0;
      do begin @(posedge ref_clk); n++; end
      while (axiRsp.arready !== 1'b1 && n < 64);
      if (n >= 64) hang();
      axiReq.arvalid <= 1'b0;
      n = 0;
      do begin @(posedge ref_clk); n++; end
      while (axiRsp.rvalid !== 1'b1 && n < 64);
      if (n >= 64) hang();
      rd = axiRsp.rdata;
      lastResp = axiRsp.rresp;
      axiReq.rready <= 1'b0;
   endtask : axiRead
   // read and compare the masked word
   // expect is a reserved word, so the read-and-compare task is expectRd
   task automatic expectRd(input logic [31:0] a, input logic [31:0] m,
                           input logic [31:0] e);
      axiRead(a);
      `CHK(rd & m, e)
   endtask : expectRd
   // hand one character to the partner
   task automatic send(input logic ir, input logic [7:0] d);
      @(posedge ref_clk);
      sendGo <= 1'b1;
      sendIr <= ir;
      sendData <= d;
      @(posedge ref_clk);
      sendGo <= 1'b0;
   endtask : send
   task automatic chkIrq(input logic e);
      @(negedge ref_clk);
      `CHK(irq, e)
   endtask : chkIrq
   // bounded wait for n decoded frames
   task automatic waitRx(input int n);
      int c;
      c = 0;
      while (usp_remote_uart_i.rxQ.size() < n && c < 5000) begin
         @(posedge ref_clk);
         c++;
      end
      if (c >= 5000) hang();
   endtask : waitRx
   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      // reset state and window bounds
      expectRd(LINE_STATUS, 32'hffffffff, 32'h20);
      expectRd(SHADOW_RX_TX_DATA_2, 32'hffffffff, 32'h0);
      expectRd(BAUD_DIV, 32'hffffffff, 32'h0000000f);
      axiWrite(SHADOW_LAST + 32'h4, 32'h11);
      `CHK(lastResp, RESP_SLVERR)
      // read just past the window: error code, zero data
      axiRead(SHADOW_LAST + 32'h4);
      `CHK(lastResp, RESP_SLVERR)
      `CHK(rd, 32'h0)
      $display("test reset done");
      // single buffer overwritten, overrun raised and routed to irq
      axiWrite(IRQ_MASK, 32'h1);
      send(1'b0, 8'h41);
      send(1'b0, 8'h42);
      expectRd(LINE_STATUS, 32'hffffffff, 32'h23);
      chkIrq(1'b1);
      expectRd(SHADOW_RX_TX_DATA_3, 32'hffffffff, 32'h42);
      expectRd(LINE_STATUS, 32'hffffffff, 32'h20);
      axiWrite(IRQ_STATUS, 32'h7);
      chkIrq(1'b0);
      $display("test overwrite done");
      // infrared input selected, wired input ignored
      axiWrite(FIFO_CONTROL, 32'h2);
      send(1'b1, 8'h5a);
      send(1'b0, 8'h33);
      expectRd(SHADOW_FIRST, 32'hffffffff, 32'h5a);
      expectRd(LINE_STATUS, 32'hffffffff, 32'h20);
      chkIrq(1'b0);
      $display("test infrared receive done");
      // receive fifo fills, seventeenth dropped, every location pops
      axiWrite(FIFO_CONTROL, 32'h1);
      for (i = 0; i < 17; i++) send(1'b0, 8'h10 + 8'(i));
      expectRd(LINE_STATUS, 32'hffffffff, 32'h23);
      chkIrq(1'b1);
      for (i = 0; i < 16; i++) begin
         expectRd(SHADOW_FIRST + 32'(4 * i), 32'hff, 32'h10 + 32'(i));
      end
      expectRd(LINE_STATUS, 32'h1, 32'h0);
      axiWrite(IRQ_STATUS, 32'h7);
      $display("test receive fifo done");
      // fifo off: holding flag drops, later write replaces pending one
      axiWrite(FIFO_CONTROL, 32'h0);
      axiWrite(BAUD_DIV, 32'h1);
      bitDiv <= 16'h0001;
      usp_remote_uart_i.rxQ.delete();
      axiWrite(SHADOW_FIRST, 32'h55);
      axiWrite(SHADOW_RX_TX_DATA_2, 32'ha6);
      expectRd(LINE_STATUS, 32'h20, 32'h0);
      axiWrite(SHADOW_LAST, 32'h3c);
      waitRx(2);
      repeat (40) @(posedge ref_clk);
      `CHK(usp_remote_uart_i.rxQ.size(), 2)
      `CHK(usp_remote_uart_i.rxQ[0], 8'h55)
      `CHK(usp_remote_uart_i.rxQ[1], 8'h3c)
      `CHK(irOutN, 1'b1)
      $display("test holding overwrite done");
      // fifo on, infrared out: sixteen held plus framer, one lost
      axiWrite(BAUD_DIV, 32'hf);
      bitDiv <= 16'h000f;
      axiWrite(IRQ_MASK, 32'h4);
      axiWrite(FIFO_CONTROL, 32'h3);
      irSel <= 1'b1;
      usp_remote_uart_i.rxQ.delete();
      for (i = 0; i < 18; i++) begin
         axiWrite(SHADOW_FIRST + 32'(4 * (i % 16)), 32'h80 + 32'(i));
      end
      chkIrq(1'b1);
      expectRd(IRQ_STATUS, 32'h4, 32'h4);
      `CHK(serOut, 1'b1)
      waitRx(17);
      repeat (200) @(posedge ref_clk);
      `CHK(usp_remote_uart_i.rxQ.size(), 17)
      for (i = 0; i < 17; i++) begin
         `CHK(usp_remote_uart_i.rxQ[i], 8'h80 + 8'(i))
      end
      $display("test transmit fifo done");
      summarize();
   end
endmodule : tb
`default_nettype wire

// >>> sim/usp_remote_uart.sv
// Purpose: remote uart model on the far side of the shadow data port
// Assumes: one character handed in per request, frames are 8N1
// Notes: decoded frames are queued for the bench to inspect
`timescale 1ns/100ps
`default_nettype none
module usp_remote_uart (
   input wire logic ref_clk,
   input wire logic sendGo,
   input wire logic sendIr,
   input wire logic [7:0] sendData,
   input wire logic irSel,
   input wire logic [15:0] bitDiv,
   input wire logic serOut,
   input wire logic irOutN,
   output var usp_pkg::usp_byte_t serRx,
   output var usp_pkg::usp_byte_t irRx
);
   import usp_pkg::*;
   logic [7:0] rxQ[$]; // decoded characters, oldest first
   logic [7:0] got; // frame being assembled
   logic line; // line the receiver listens to
   int k;
   assign line = irSel ? irOutN : serOut;
   initial begin
      serRx = '0;
      irRx = '0;
   end
   // one strobe per request; idle data toggles so stale bytes never hold
   always @(posedge ref_clk) begin
      serRx.valid <= sendGo && !sendIr;
      irRx.valid <= sendGo && sendIr;
      serRx.data <= (sendGo && !sendIr) ? sendData : ~serRx.data;
      irRx.data <= (sendGo && sendIr) ? sendData : ~irRx.data;
   end
   // receiver: start low, eight bits lsb first, stop high
   initial begin
      forever begin
         @(posedge ref_clk);
         if (line === 1'b0) begin
            repeat ((bitDiv + 1) / 2) @(posedge ref_clk);
            for (k = 0; k < 8; k++) begin
               repeat (bitDiv + 1) @(posedge ref_clk);
               got[k] = line;
            end
            repeat (bitDiv + 1) @(posedge ref_clk);
            // a broken stop bit drops the frame, so counts expose it
            if (line === 1'b1) begin
               rxQ.push_back(got);
            end
         end
      end
   end
endmodule : usp_remote_uart
`default_nettype wire
